// *** cpbe_cfg.svh ***
// timing counts, field lengths and error limits of the protocol bit engine
// assumes inclusion by the package and the engine only
`ifndef CPBE_CFG_SVH
`define CPBE_CFG_SVH
`define CPBE_CLK_MHZ        40
`define CPBE_JUDGE_CLKS     3
`define CPBE_STUFF_LEN      5
`define CPBE_TQ_MIN         8
`define CPBE_TQ_MAX         25
`define CPBE_PRE_MIN        2
`define CPBE_PRE_MAX_NORM   128
`define CPBE_PRE_MAX_EXT    256
`define CPBE_PASSIVE_LIM    127
`define CPBE_BUSOFF_LIM     255
`define CPBE_WARN_LIM       96
`define CPBE_TX_ERR_INC     8
`define CPBE_FLAG_BITS      6
`define CPBE_DELIM_BITS     8
`define CPBE_EOF_BITS       7
`define CPBE_INTER_BITS     3
`define CPBE_IDLE_RECOV     11
`endif

// *** cpbe_pkg.sv ***
// types shared by the protocol bit engine
// assumes cpbe_cfg.svh sits in the include path
`include "cpbe_cfg.svh"
package cpbe_pkg;
  typedef enum logic [1:0] {
    CPBE_ERR_ACTIVE  = 2'b00,
    CPBE_ERR_PASSIVE = 2'b01,
    CPBE_BUS_OFF     = 2'b10
  } cpbe_errst_e;

  typedef enum logic [2:0] {
    CPBE_IDLE  = 3'b000,
    CPBE_FRAME = 3'b001,
    CPBE_EFLAG = 3'b010,
    CPBE_EDLM  = 3'b011,
    CPBE_EOFS  = 3'b100,
    CPBE_INTER = 3'b101,
    CPBE_OVLD  = 3'b110,
    CPBE_SLEEP = 3'b111
  } cpbe_state_e;

  // time segment setup, in quanta; prescale holds ratio minus one
  typedef struct packed {
    logic [7:0] prescale;
    logic       rangeExtend;
    logic [3:0] propSeg;
    logic [3:0] phase1;
    logic [3:0] phase2;
    logic [1:0] jumpWidth;
  } cpbe_timing_s;

  // one bit to send: data level and whether it belongs to arbitration
  typedef struct packed {
    logic level;
    logic arbField;
    logic lastBit;
  } cpbe_txbit_s;

  typedef struct packed {
    logic       level;
    logic       isStuff;
  } cpbe_rxbit_s;

  typedef struct packed {
    logic [7:0] txErrCnt;
    logic [6:0] rxErrCnt;
    cpbe_errst_e errState;
    logic       warn;
  } cpbe_errinfo_s;
endpackage : cpbe_pkg

// *** cpbe_engine.sv ***
// bit engine of a CAN node: timing, sync, stuffing, arbitration, fault counters
// assumes a CPU block feeding config ports and bit streams; canRx is a pin
//
// Behaviour
// - first node driving from idle owns bus
// - compare sent arbitration bit with bus
// - dominant request bit beats recessive one
// - stuff opposite bit after five equal bits
// - sleep wakes on bus, stop only by CPU
// - retransmit disturbed frame after error frame
// - two error counters give three states
// - missing acknowledge never drives bus off
// - count errors up, successes down, at delimiter
// - dominant sample in intermission sends overload
// - use old counts, bump after flag
// - prescaler ratio 2..128 or 2..256
// - nominal bit spans 8 to 25 quanta
// - judge sampled level for three clocks
// - transmit own timing, receive on edges
// - idle falling edge hard-syncs bit timing
// - hard sync only at first edge
// - resync only after recessive sample
// - jump width limits phase correction
// - sixteen-bit read, paired set clear write
`timescale 1ns/100ps
`include "cpbe_cfg.svh"
module cpbe_engine
  import cpbe_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               canRx,
  output logic                    canTx,
  input  wire cpbe_pkg::cpbe_timing_s timing,
  input  wire logic               sleepReq,
  input  wire logic               stopReq,
  input  wire logic               cpuAccess,
  input  wire logic               ctrlWrStb,
  input  wire logic [15:0]        ctrlWrData,
  output logic [15:0]             ctrlRdData,
  input  wire logic               txValid,
  output logic                    txReady,
  input  wire cpbe_pkg::cpbe_txbit_s txBit,
  input  wire logic               ackMissing,
  output logic                    rxValid,
  input  wire logic               rxReady,
  output cpbe_pkg::cpbe_rxbit_s   rxData,
  output logic                    arbLost,
  output logic                    retransmit,
  output logic                    transmitting,
  output logic                    sleeping,
  output cpbe_pkg::cpbe_errinfo_s errInfo
);
  import cpbe_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  rxSync;
    logic        rxPrev;
    logic [7:0]  preCnt;
    logic [4:0]  tqCnt;
    logic [4:0]  phase1Ext;
    logic        shortP2;
    logic [1:0]  judgeCnt;
    logic        sampled;
    logic        prevSample;
    logic        synced;
    logic        hardDone;
    logic        driving;
    logic        txLevel;
    logic        arb;
    logic [2:0]  runLen;
    logic        runLevel;
    logic        stuffNext;
    cpbe_state_e st;
    logic [3:0]  fieldCnt;
    logic        wasTx;
    logic        stopped;
    logic [7:0]  tec;
    logic [6:0]  rec;
    logic        passivePend;
    logic [7:0]  ctrlBits;
    logic [1:0]  bufCnt;
    cpbe_rxbit_s buf0;
    cpbe_rxbit_s buf1;
    logic        arbLost;
    logic        retransmit;
    logic        bitErrSeen;
  } cpbe_core_s;

  cpbe_core_s cur_r;
  cpbe_core_s cur_nxt;

  localparam logic [1:0] JUDGE_CYC = 2'(`CPBE_JUDGE_CLKS);

  logic [4:0] segSync;
  logic [4:0] segSample;
  logic [4:0] segEnd;
  logic [7:0] preMax;
  logic [7:0] preUse;
  logic       tqTick;
  logic       rxLvl;
  logic       edgeFall;
  logic       samplePt;
  logic       bitEnd;
  logic       bitErr;
  logic       busOff;
  logic       bufPush;
  logic       bufPop;
  logic [4:0] sjw;

  always_comb begin
    // ratio minus one clamped to the selected range
    preMax = timing.rangeExtend ? 8'hFF : 8'h7F;
    preUse = (timing.prescale > preMax) ? preMax : timing.prescale;
    if (preUse == 8'h00) begin
      preUse = 8'h01;
    end
    sjw = 5'(timing.jumpWidth) + 5'h01;
    // sync + prop + ph1 + ph2, bounded to 8..25 quanta
    // quantum 0 is sync, so the sample point ends quantum prop + ph1
    segSample = 5'(timing.propSeg) + 5'(timing.phase1) + cur_r.phase1Ext;
    segEnd = segSample + 5'(timing.phase2);
    if (segEnd < 5'(`CPBE_TQ_MIN - 1)) begin
      segEnd = 5'(`CPBE_TQ_MIN - 1);
    end
    if (segEnd > 5'(`CPBE_TQ_MAX - 1)) begin
      segEnd = 5'(`CPBE_TQ_MAX - 1);
    end
    if (cur_r.shortP2) begin
      segEnd = (segEnd > segSample + sjw) ? segEnd - sjw : segSample;
    end
    segSync = 5'h00;
  end

  assign rxLvl    = cur_r.rxSync[1];
  assign tqTick   = (cur_r.preCnt == preUse);
  assign edgeFall = cur_r.rxPrev & ~rxLvl;
  assign samplePt = tqTick & (cur_r.tqCnt == segSample);
  assign bitEnd   = tqTick & (cur_r.tqCnt >= segEnd);
  assign busOff   = (cur_r.tec == 8'hFF) & cur_r.passivePend;
  assign bitErr   = samplePt & cur_r.driving & (cur_r.txLevel != rxLvl);
  assign bufPop   = rxReady & (cur_r.bufCnt != 2'h0);
  assign bufPush  = samplePt & (cur_r.st == CPBE_FRAME) & ~cur_r.driving;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       levelOut;
    logic       ph;
    levelOut = 1'b1;
    ph = 1'b0;
    cur_nxt = cur_r;
    cur_nxt.rxSync = {cur_r.rxSync[0], canRx};
    cur_nxt.rxPrev = rxLvl;
    cur_nxt.arbLost = 1'b0;
    cur_nxt.retransmit = 1'b0;
    cur_nxt.preCnt = tqTick ? 8'h00 : cur_r.preCnt + 8'h01;
    if (tqTick) begin
      cur_nxt.tqCnt = bitEnd ? 5'h00 : cur_r.tqCnt + 5'h01;
    end
    if (bitEnd) begin
      cur_nxt.phase1Ext = 5'h00;
      cur_nxt.shortP2 = 1'b0;
      cur_nxt.bitErrSeen = 1'b0;
    end
    // a recessive arbitration bit overwritten is a loss, not an error
    if (bitErr & ~(cur_r.arb & cur_r.txLevel)) begin
      cur_nxt.bitErrSeen = 1'b1;
    end
    // only the first idle edge after reset or wake restarts timing
    if (edgeFall & ~cur_r.hardDone & (cur_r.st == CPBE_IDLE)) begin
      cur_nxt.tqCnt = 5'h01;
      cur_nxt.preCnt = 8'h00;
      cur_nxt.hardDone = 1'b1;
      cur_nxt.synced = 1'b1;
    end else if ((rxLvl != cur_r.rxPrev) & cur_r.prevSample & ~cur_r.driving
                 & cur_r.hardDone) begin
      ph = (cur_r.tqCnt <= segSample);
      if (ph) begin
        // positive error lengthens phase 1 by at most jump width
        cur_nxt.phase1Ext = (cur_r.tqCnt <= sjw) ? cur_r.tqCnt : sjw;
      end else if ((segEnd - cur_r.tqCnt) < sjw) begin
        cur_nxt.tqCnt = 5'h00;
      end else begin
        cur_nxt.shortP2 = 1'b1;
      end
    end
    // sampled level settles for three base clocks before use
    if (samplePt) begin
      cur_nxt.judgeCnt = JUDGE_CYC;
      cur_nxt.sampled = rxLvl;
    end else if (cur_r.judgeCnt != 2'h0) begin
      cur_nxt.judgeCnt = cur_r.judgeCnt - 2'h1;
      if (cur_r.judgeCnt == 2'h1) begin
        cur_nxt.prevSample = cur_r.sampled;
      end
    end
    // stuff run tracking on every sampled frame bit
    if (samplePt & (cur_r.st == CPBE_FRAME)) begin
      if (cur_r.stuffNext & (rxLvl != cur_r.runLevel)) begin
        cur_nxt.stuffNext = 1'b0;
        cur_nxt.runLevel = rxLvl;
        cur_nxt.runLen = 3'h1;
      end else if (cur_r.stuffNext) begin
        // sixth equal bit: no stuff came, the run keeps counting toward frame end
        cur_nxt.stuffNext = 1'b0;
        cur_nxt.runLen = (cur_r.runLen == 3'h7) ? 3'h7 : cur_r.runLen + 3'h1;
      end else if (rxLvl == cur_r.runLevel) begin
        cur_nxt.runLen = (cur_r.runLen == 3'h7) ? 3'h7 : cur_r.runLen + 3'h1;
        cur_nxt.stuffNext = (cur_r.runLen == 3'(`CPBE_STUFF_LEN - 1));
      end else begin
        cur_nxt.runLevel = rxLvl;
        cur_nxt.runLen = 3'h1;
      end
      // recessive sent but dominant seen in arbitration means loss
      if (cur_r.driving & cur_r.arb & cur_r.txLevel & ~rxLvl) begin
        cur_nxt.driving = 1'b0;
        cur_nxt.arbLost = 1'b1;
      end
    end
    // two-entry receive buffer; a stall holds two words and drops bits pushed while full
    if (bufPop) begin
      cur_nxt.buf0 = cur_r.buf1;
    end
    if (bufPush & (cur_r.bufCnt - 2'(bufPop) != 2'h2)) begin
      if ((cur_r.bufCnt - 2'(bufPop)) == 2'h0) begin
        cur_nxt.buf0 = '{level: rxLvl, isStuff: cur_r.stuffNext};
      end else begin
        cur_nxt.buf1 = '{level: rxLvl, isStuff: cur_r.stuffNext};
      end
    end
    cur_nxt.bufCnt = cur_r.bufCnt - 2'(bufPop)
                     + 2'(bufPush & (cur_r.bufCnt - 2'(bufPop) != 2'h2));
    // frame sequencer
    if (bitEnd) begin
      case (cur_r.st)
        CPBE_IDLE: begin
          cur_nxt.fieldCnt = 4'h0;
          if (txValid & ~busOff & ~cur_r.stopped) begin
            cur_nxt.st = CPBE_FRAME;
            cur_nxt.driving = 1'b1;
            cur_nxt.wasTx = 1'b1;
          end else if (~cur_r.prevSample) begin
            cur_nxt.st = CPBE_FRAME;
            cur_nxt.wasTx = 1'b0;
          end
          // the dominant start bit opens the first stuff run
          cur_nxt.runLen = 3'h1;
          cur_nxt.runLevel = 1'b0;
          cur_nxt.stuffNext = 1'b0;
          if (sleepReq | stopReq) begin
            cur_nxt.st = CPBE_SLEEP;
            cur_nxt.stopped = stopReq;
            cur_nxt.driving = 1'b0;
          end
        end
        CPBE_FRAME: begin
          if (cur_r.driving & (cur_r.bitErrSeen | ackMissing)) begin
            cur_nxt.st = CPBE_EFLAG;
            cur_nxt.fieldCnt = 4'h0;
          end else if (cur_r.driving & txBit.lastBit & ~cur_r.stuffNext) begin
            cur_nxt.st = CPBE_EOFS;
            cur_nxt.fieldCnt = 4'h0;
            cur_nxt.driving = 1'b0;
            if (cur_r.tec != 8'h00) begin
              cur_nxt.tec = cur_r.tec - 8'h01;
            end
          end else if (~cur_r.driving & cur_r.prevSample & (cur_r.runLen == 3'h7)) begin
            cur_nxt.st = CPBE_EOFS;
            if (cur_r.rec != 7'h00) begin
              cur_nxt.rec = cur_r.rec - 7'h01;
            end
          end
        end
        CPBE_EFLAG: begin
          cur_nxt.fieldCnt = cur_r.fieldCnt + 4'h1;
          if (cur_r.fieldCnt == 4'(`CPBE_FLAG_BITS - 1)) begin
            cur_nxt.st = CPBE_EDLM;
            cur_nxt.fieldCnt = 4'h0;
            // bump once the flag is out, judged on the old count
            if (cur_r.wasTx) begin
              if (~ackMissing | (errInfo.errState == CPBE_ERR_ACTIVE)) begin
                cur_nxt.tec = (cur_r.tec > 8'(`CPBE_BUSOFF_LIM - `CPBE_TX_ERR_INC))
                              ? 8'hFF : cur_r.tec + 8'(`CPBE_TX_ERR_INC);
                cur_nxt.passivePend = (cur_r.tec > 8'(`CPBE_BUSOFF_LIM
                                       - `CPBE_TX_ERR_INC)) & ~ackMissing;
              end
            end else if (cur_r.rec != 7'h7F) begin
              cur_nxt.rec = cur_r.rec + 7'h01;
            end
          end
        end
        CPBE_EDLM: begin
          cur_nxt.fieldCnt = cur_r.fieldCnt + 4'h1;
          if (cur_r.fieldCnt == 4'(`CPBE_DELIM_BITS - 1)) begin
            cur_nxt.st = CPBE_INTER;
            cur_nxt.fieldCnt = 4'h0;
            cur_nxt.retransmit = cur_r.wasTx;
          end
        end
        CPBE_EOFS: begin
          cur_nxt.fieldCnt = cur_r.fieldCnt + 4'h1;
          if (cur_r.fieldCnt == 4'(`CPBE_EOF_BITS - 1)) begin
            cur_nxt.st = CPBE_INTER;
            cur_nxt.fieldCnt = 4'h0;
          end
        end
        CPBE_INTER: begin
          cur_nxt.fieldCnt = cur_r.fieldCnt + 4'h1;
          if (~cur_r.prevSample) begin
            cur_nxt.st = CPBE_OVLD;
            cur_nxt.fieldCnt = 4'h0;
          end else if (cur_r.fieldCnt == 4'(`CPBE_INTER_BITS - 1)) begin
            cur_nxt.st = CPBE_IDLE;
            cur_nxt.driving = cur_r.wasTx & txValid & ~busOff;
          end
        end
        CPBE_OVLD: begin
          cur_nxt.fieldCnt = cur_r.fieldCnt + 4'h1;
          if (cur_r.fieldCnt == 4'(`CPBE_FLAG_BITS - 1)) begin
            cur_nxt.st = CPBE_EDLM;
            cur_nxt.fieldCnt = 4'h0;
            cur_nxt.wasTx = 1'b0;
          end
        end
        CPBE_SLEEP: begin
          // left only by a bus edge or a cpu access, below
          cur_nxt.st = CPBE_SLEEP;
        end
        default: cur_nxt.st = CPBE_IDLE;
      endcase
    end
    // sleep wakes on bus edge, stop waits for the CPU
    if (cur_r.st == CPBE_SLEEP) begin
      if ((edgeFall & ~cur_r.stopped) | (cur_r.stopped & cpuAccess)) begin
        cur_nxt.st = CPBE_IDLE;
        cur_nxt.stopped = 1'b0;
        cur_nxt.hardDone = 1'b0;
      end
    end
    if (samplePt) begin
      levelOut = txBit.level;
      cur_nxt.txLevel = (cur_r.st == CPBE_EFLAG) | (cur_r.st == CPBE_OVLD) ? 1'b0
                        : (cur_r.stuffNext ? ~cur_r.runLevel : levelOut);
      cur_nxt.arb = txBit.arbField;
    end
    // upper byte selects set, lower byte clears; equal pair holds
    if (ctrlWrStb) begin
      cur_nxt.ctrlBits = (cur_r.ctrlBits | (ctrlWrData[15:8] & ~ctrlWrData[7:0]))
                         & ~(ctrlWrData[7:0] & ~ctrlWrData[15:8]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_r <= '{rxSync: 2'h3, rxPrev: 1'b1, sampled: 1'b1, prevSample: 1'b1,
                 txLevel: 1'b1, st: CPBE_IDLE, default: '0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    errInfo.txErrCnt = cur_r.tec;
    errInfo.rxErrCnt = cur_r.rec;
    if (busOff) begin
      errInfo.errState = CPBE_BUS_OFF;
    end else if ((cur_r.tec > 8'(`CPBE_PASSIVE_LIM)) | (cur_r.rec == 7'h7F)) begin
      errInfo.errState = CPBE_ERR_PASSIVE;
    end else begin
      errInfo.errState = CPBE_ERR_ACTIVE;
    end
    errInfo.warn = (cur_r.tec >= 8'(`CPBE_WARN_LIM))
                   | (cur_r.rec >= 7'(`CPBE_WARN_LIM));
  end

  assign canTx        = cur_r.driving ? cur_r.txLevel : 1'b1;
  assign txReady      = samplePt & cur_r.driving & ~cur_r.stuffNext;
  assign rxValid      = (cur_r.bufCnt != 2'h0);
  assign rxData       = cur_r.buf0;
  assign ctrlRdData   = {8'h00, cur_r.ctrlBits};
  assign arbLost      = cur_r.arbLost;
  assign retransmit   = cur_r.retransmit;
  assign transmitting = cur_r.driving;
  assign sleeping     = (cur_r.st == CPBE_SLEEP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_setclr;
    @(posedge clk) disable iff (sys_rst)
      ctrlWrStb |=> ctrlRdData[7:0] == (($past(ctrlRdData[7:0]) | ($past(ctrlWrData[15:8])
        & ~$past(ctrlWrData[7:0]))) & ~($past(ctrlWrData[7:0]) & ~$past(ctrlWrData[15:8])));
  endproperty
  a_setclr: assert property (p_setclr) else $error("set clear write wrong");

  property p_arblost;
    @(posedge clk) disable iff (sys_rst)
      arbLost |-> !transmitting;
  endproperty
  a_arblost: assert property (p_arblost) else $error("still driving after loss");

  property p_passive;
    @(posedge clk) disable iff (sys_rst)
      (errInfo.txErrCnt > 8'd127 && errInfo.errState != CPBE_BUS_OFF)
        |-> errInfo.errState == CPBE_ERR_PASSIVE;
  endproperty
  a_passive: assert property (p_passive) else $error("passive state missed");

  property p_warn;
    @(posedge clk) disable iff (sys_rst)
      (errInfo.txErrCnt >= 8'd96) |-> errInfo.warn;
  endproperty
  a_warn: assert property (p_warn) else $error("warning missed");

  property p_recess;
    @(posedge clk) disable iff (sys_rst)
      !transmitting |-> canTx;
  endproperty
  a_recess: assert property (p_recess) else $error("bus driven while idle");

  property p_judge;
    @(posedge clk) disable iff (sys_rst)
      samplePt |=> cur_r.judgeCnt == 2'd3;
  endproperty
  a_judge: assert property (p_judge) else $error("judge interval wrong");

  property p_stop;
    @(posedge clk) disable iff (sys_rst)
      (sleeping && cur_r.stopped && !cpuAccess) |=> sleeping;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left without cpu");

  property p_cntstep;
    @(posedge clk) disable iff (sys_rst)
      errInfo.rxErrCnt != $past(errInfo.rxErrCnt) |-> bitEnd ||
        $past(bitEnd);
  endproperty
  a_cntstep: assert property (p_cntstep) else $error("count moved off bit");
endmodule : cpbe_engine

// *** cpbe_peer_node.sv ***
// other node on the wired bus: drives a scripted bit string, recessive otherwise
// assumes the bench ands peerTx with the engine's canTx to form the bus level
`timescale 1ns/100ps
module cpbe_peer_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output logic      peerTx
);
  initial peerTx = 1'b1;

  // ----
  // frame driver
  // ----
  // bits go out msb first on this node's own timing; released (pull-up) after
  task automatic send_bits(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      peerTx = bits[i];
      repeat (BIT_CLKS - 1) @(negedge clk);
    end
    @(negedge clk);
    peerTx = 1'b1;
  endtask : send_bits
endmodule : cpbe_peer_node

// *** can_protocol_bit_engine_test.sv ***
// self-checking bench of the protocol bit engine
// assumes cpbe_pkg, cpbe_engine and cpbe_peer_node are compiled first
`timescale 1ns/100ps
module can_protocol_bit_engine_test;
  import cpbe_pkg::*;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
  } cpbe_row_s;

  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          canTx, peerTx, txReady, rxValid, arbLost, retransmit;
  logic          transmitting, sleeping;
  logic          sleepReq = 1'b0, stopReq = 1'b0, cpuAccess = 1'b0;
  logic          ctrlWrStb = 1'b0, txValid = 1'b0, rxReady = 1'b1;
  logic [15:0]   ctrlWrData = 16'h0000;
  logic [15:0]   ctrlRdData;
  cpbe_txbit_s   txBit = 3'h0;
  cpbe_rxbit_s   rxData;
  cpbe_errinfo_s errInfo;
  cpbe_rxbit_s   rxQ[$];
  logic          seenArb = 1'b0;
  logic [10:0]   rxPat = 11'b00000111011;
  int            errors = 0, num_checks = 0;
  // bit = 1 + 2 + 3 + 2 quanta of two clocks: 16 clocks, the shortest legal bit
  cpbe_timing_s  timing = '{8'h01, 1'b0, 4'h2, 4'h3, 4'h2, 2'h0};
  cpbe_row_s     rows[6] = '{'{16'h0100, 16'h0001}, '{16'hFF00, 16'h00FF},
                             '{16'h00F0, 16'h000F}, '{16'hAAAA, 16'h000F},
                             '{16'h0055, 16'h000A}, '{16'h5500, 16'h005F}};

  always #12.5 clk = ~clk;

  cpbe_engine dut (.clk(clk), .sys_rst(sys_rst), .canRx(canTx & peerTx), .canTx(canTx),
    .timing(timing), .sleepReq(sleepReq), .stopReq(stopReq), .cpuAccess(cpuAccess),
    .ctrlWrStb(ctrlWrStb), .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData),
    .txValid(txValid), .txReady(txReady), .txBit(txBit), .ackMissing(1'b0),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .arbLost(arbLost),
    .retransmit(retransmit), .transmitting(transmitting), .sleeping(sleeping),
    .errInfo(errInfo));
  cpbe_peer_node #(.BIT_CLKS(16)) peer (.clk(clk), .peerTx(peerTx));

  always @(posedge clk) begin
    if (rxValid && rxReady) rxQ.push_back(rxData);
    seenArb <= seenArb | arbLost;
  end

  // ----
  // compare and wait helpers
  // ----
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic wait_sleep(input logic want);
    for (int n = 0; n < 200 && sleeping !== want; n++) @(negedge clk);
  endtask : wait_sleep

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    check_val({canTx, transmitting, sleeping}, 3'b100);
    check_val(errInfo, {8'h00, 7'h00, CPBE_ERR_ACTIVE, 1'b0});
    check_val(ctrlRdData, 16'h0000);
    $display("reset test done");
    // only paired set/clear writes are issued, never read-modify-write
    ctrlWrStb = 1'b1;
    foreach (rows[i]) begin
      ctrlWrData = rows[i].wr;
      @(negedge clk);
      check_val(ctrlRdData, rows[i].rd);
    end
    ctrlWrStb = 1'b0;
    $display("set clear table done");
    // five dominant bits then a stuff bit; the receiver stalls for 20 clocks mid-frame
    fork
      peer.send_bits(32'h0000003B, 11);
      begin
        repeat (40) @(negedge clk);
        rxReady = 1'b0;
        repeat (20) @(negedge clk);
        rxReady = 1'b1;
      end
    join
    repeat (64) @(negedge clk);
    // the start bit is consumed by idle detection; words begin with bit 1
    check_val(rxQ.size() >= 10, 1'b1);
    for (int i = 1; i < 11 && i <= rxQ.size(); i++)
      check_val(rxQ[i - 1], {rxPat[10 - i], 1'(i == 5)});
    $display("receive stuff test done");
    repeat (480) @(negedge clk);
    // recessive arbitration bits against a peer holding the bus dominant
    txValid = 1'b1;
    txBit = '{1'b1, 1'b1, 1'b0};
    for (int n = 0; n < 3000 && transmitting !== 1'b1; n++) @(negedge clk);
    check_val(transmitting, 1'b1);
    peer.send_bits(32'h0, 12);
    check_val({seenArb, transmitting}, 2'b10);
    txValid = 1'b0;
    $display("arbitration test done");
    repeat (640) @(negedge clk);
    // stop ignores the bus and is left only by a cpu access
    stopReq = 1'b1;
    wait_sleep(1'b1);
    stopReq = 1'b0;
    peer.send_bits(32'h5, 4);
    repeat (32) @(negedge clk);
    check_val(sleeping, 1'b1);
    cpuAccess = 1'b1;
    @(negedge clk);
    cpuAccess = 1'b0;
    wait_sleep(1'b0);
    check_val(sleeping, 1'b0);
    // sleep wakes on bus activity
    sleepReq = 1'b1;
    wait_sleep(1'b1);
    check_val(sleeping, 1'b1);
    sleepReq = 1'b0;
    peer.send_bits(32'h0, 2);
    wait_sleep(1'b0);
    check_val(sleeping, 1'b0);
    $display("low power test done");
    close_out();
  end
endmodule : can_protocol_bit_engine_test
